// file: dv/fsf_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: one-cycle strobes, one request at a time
module fsf_host_model
   import fsf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       mon_zero,   // Second monitor input sits at 0 V
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output reg_req_t        req
);
   initial req = '0;

   // Write strobe for one cycle, then let derived outputs settle one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      // Power-down is only requested with the monitor grounded
      if (a == ADDR_SW_POWER_DOWN_CTRL && d[BIT_SW_POWER_DOWN] && !mon_zero) begin
         d[BIT_SW_POWER_DOWN] = 1'b0;
      end
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1;
   endtask

   // Read strobe; the answer is sampled just after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      d = rd_data;
      v = rd_valid;
   endtask
endmodule

// file: dv/fuse_and_special_function_control_tb.sv
`timescale 1ns/1ps
// Register-level test of the fuse and special function bank
module fuse_and_special_function_control_tb;
   import fsf_pkg::*;
   logic       clk_sys = 1'b0;
   logic       nrst = 1'b0;
   logic       lock_sense = 1'b0;    // Blown lock fuse when high
   logic       prog_req = 1'b0;      // Fuse blow request pulse
   reg_req_t   req;
   logic [7:0] rd_data;
   logic       rd_valid;
   wire  [5:0] outs;                 // Level outputs gathered for one compare
   logic       go;
   int         miscompares = 0;
   int         n_tests = 0;
   int         cycles = 0;

   always #5 clk_sys = ~clk_sys;

   fsf_host_model fsf_host_model_inst (
      .clk      (clk_sys),
      .mon_zero (1'b1),
      .rd_data  (rd_data),
      .rd_valid (rd_valid),
      .req      (req)
   );

   fuse_and_special_function_control fuse_and_special_function_control_inst (
      .CLK_SYS            (clk_sys),
      .NRST               (nrst),
      .REG_REQ            (req),
      .FUSE_LOCK_SENSE    (lock_sense),
      .FUSE_PROG_REQ      (prog_req),
      .RD_DATA            (rd_data),
      .RD_VALID           (rd_valid),
      .SENSE_CURRENT_LOW  (outs[0]),
      .FUSE_BLOW_EN       (outs[1]),
      .FUSE_PROG_GO       (go),
      .SHUTDOWN_OUTPUT_O  (outs[2]),
      .SHUTDOWN_OUTPUT_OE (outs[3]),
      .OVERRIDE_ACTIVE    (outs[4]),
      .POWER_DOWN         (outs[5])
   );

   // One compare, reported at once on mismatch
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Read through the host and check data and the valid pulse
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      fsf_host_model_inst.rd(a, d, v);
      chk("rd_valid", 8'h01, {7'h00, v});
      chk("rd_data", exp, d);
      // Valid is a single-cycle pulse, so it must drop one edge later
      @(posedge clk_sys);
      #1;
      chk("rd_valid", 8'h00, {7'h00, rd_valid});
   endtask

   // Blow request; the go pulse stands one cycle after the request edge
   task automatic prog(input logic exp);
      @(posedge clk_sys);
      prog_req <= 1'b1;
      @(posedge clk_sys);
      prog_req <= 1'b0;
      #1;
      chk("fuse_prog_go", {7'h00, exp}, {7'h00, go});
   endtask

   task automatic results();
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard, generous against roughly 100 cycles of traffic
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int a = 8'h15; a <= 8'h19; a++) begin
         rdchk(8'(a), 8'h00);
      end
      chk("outs", 8'h00, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'hFF);
      rdchk(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'h0F);
      chk("outs", 8'h1B, {2'b00, outs});
      prog(1'b1);
      // Software cannot set the lock; only the fuse sense can
      fsf_host_model_inst.wr(ADDR_FUSE_PROGRAM_LOCK, 8'hFF);
      rdchk(ADDR_FUSE_PROGRAM_LOCK, 8'h00);
      @(posedge clk_sys);
      lock_sense <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdchk(ADDR_FUSE_PROGRAM_LOCK, 8'h08);
      chk("outs", 8'h19, {2'b00, outs});
      prog(1'b0);
      @(posedge clk_sys);
      lock_sense <= 1'b0;
      repeat (3) @(posedge clk_sys);
      fsf_host_model_inst.wr(ADDR_SW_POWER_DOWN_CTRL, 8'hFF);
      rdchk(ADDR_SW_POWER_DOWN_CTRL, 8'h01);
      chk("outs", 8'h3B, {2'b00, outs});
      // Lockout bits one at a time, each accumulating
      fsf_host_model_inst.wr(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h02);
      chk("outs", 8'h39, {2'b00, outs});
      prog(1'b0);
      fsf_host_model_inst.wr(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h08);
      chk("outs", 8'h19, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h10);
      chk("outs", 8'h11, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h01);
      chk("outs", 8'h01, {2'b00, outs});
      // Low three bits stay writable, the override bit is frozen
      fsf_host_model_inst.wr(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'h00);
      rdchk(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'h08);
      chk("outs", 8'h00, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h00);
      rdchk(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h1B);
      // Only a power cycle clears the lockout bits
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rdchk(ADDR_SPECIAL_FUNC_LOCKOUT, 8'h00);
      chk("outs", 8'h00, {2'b00, outs});
      // With no lockout control bits 0 and 2 and the power-down bit follow their writes both ways
      fsf_host_model_inst.wr(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'h05);
      chk("outs", 8'h09, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_OTP_AND_SHUTDOWN_CTRL, 8'h00);
      chk("outs", 8'h00, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_SW_POWER_DOWN_CTRL, 8'h01);
      chk("outs", 8'h20, {2'b00, outs});
      fsf_host_model_inst.wr(ADDR_SW_POWER_DOWN_CTRL, 8'h00);
      chk("outs", 8'h00, {2'b00, outs});
      results();
   end
endmodule

// file: hdl/fsf_pkg.sv
package fsf_pkg;

   // Register offsets on the serial register port
   localparam logic [7:0] ADDR_FUSE_PROGRAM_LOCK      = 8'h15;
   localparam logic [7:0] ADDR_OTP_AND_SHUTDOWN_CTRL  = 8'h16;
   localparam logic [7:0] ADDR_SW_POWER_DOWN_CTRL     = 8'h17;
   localparam logic [7:0] ADDR_SPECIAL_FUNC_LOCKOUT   = 8'h18;

   // Power-on value of the control, power-down and lockout registers; the lock register reads the fuse
   localparam logic [7:0] REG_RESET                   = 8'h00;

   // Fuse program lock fields
   localparam int         BIT_LOCK_FUSE               = 3;

   // OTP and shutdown control fields
   localparam int         BIT_SENSE_LOW               = 0;
   localparam int         BIT_BLOW_ENABLE             = 1;
   localparam int         BIT_SW_SHUTDOWN             = 2;
   localparam int         BIT_OVERRIDE                = 3;

   // Software power-down fields
   localparam int         BIT_SW_POWER_DOWN           = 0;

   // Lockout fields
   localparam int         BIT_LO_OVERRIDE             = 0;
   localparam int         BIT_LO_FUSE                 = 1;
   localparam int         BIT_LO_POWER_DOWN           = 3;
   localparam int         BIT_LO_SHUTDOWN             = 4;

   // Implemented bits per register, plus the lockout-guarded control bit; all others read zero
   localparam logic [7:0] MASK_LOCK                   = 8'h08;
   localparam logic [7:0] MASK_CTRL                   = 8'h0F;
   localparam logic [7:0] MASK_CTRL_GUARDED           = 8'h08;
   localparam logic [7:0] MASK_POWER_DOWN             = 8'h01;
   localparam logic [7:0] MASK_LOCKOUT                = 8'h1B;

   // One register access from the serial byte engine
   typedef struct packed {
      logic       wr;     // One-cycle write strobe
      logic       rd;     // One-cycle read strobe
      logic [7:0] addr;   // Register offset
      logic [7:0] wdata;  // Write byte
   } reg_req_t;

endpackage

// file: hdl/fsf_sync2.sv
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from outside the clock domain
module fsf_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;   // Only read by the second stage

   // First stage may go metastable; nothing else looks at it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
      end else begin
         stage1 <= async_in;
      end
   end

   // Second stage is the clean copy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_out <= '0;
      end else begin
         sync_out <= stage1;
      end
   end

endmodule

// file: hdl/fuse_and_special_function_control.sv
`timescale 1ns/1ps
// Contract
// - Lock bit blocks further programming; fuse-set only
// - Control bit0 selects low fuse sense current
// - Control bit1 gates fuse blowing
// - Control bit2 pulls shutdown output low
// - Control bit3 lets registers override fuses
// - Power-down bit0 requests software power-down
// - Lockout bit0 blocks override except listed bits
// - Lockout bit1 disables fuse programming entirely
// - Lockout bit3 disables software power-down
// - Lockout bit4 disables software shutdown assertion
// - Lockout bits set-only until power cycle
module fuse_and_special_function_control
   import fsf_pkg::*;
(
   input  wire logic     CLK_SYS,
   input  wire logic     NRST,
   input  wire reg_req_t REG_REQ,
   input  wire logic     FUSE_LOCK_SENSE,
   input  wire logic     FUSE_PROG_REQ,
   output logic [7:0]    RD_DATA,
   output logic          RD_VALID,
   output logic          SENSE_CURRENT_LOW,
   output logic          FUSE_BLOW_EN,
   output logic          FUSE_PROG_GO,
   output logic          SHUTDOWN_OUTPUT_O,
   output logic          SHUTDOWN_OUTPUT_OE,
   output logic          OVERRIDE_ACTIVE,
   output logic          POWER_DOWN
);

   // Register storage
   logic [7:0] ctrl;          // OTP and shutdown control
   logic [7:0] pwr;           // Software power-down control
   logic [7:0] lockout;       // Special function lockout, set-only
   logic       lock_fuse;     // Synchronised state of the lock fuse

   // Combinational helpers
   logic [7:0] ctrl_wmask;    // Writable control bits this cycle
   logic       fuse_ok;       // Fuse programming allowed right now
   logic [7:0] next_rdata;    // Read mux output

   // Register hit for a strobed access
   function automatic logic hit(input logic strobe, input logic [7:0] a,
                                input logic [7:0] target);
      hit = strobe && (a == target);
   endfunction

   // Lock fuse sits in the analog array, so it is asynchronous here
   fsf_sync2 #(
      .WIDTH    (1)
   ) u_lock_sync (
      .clk      (CLK_SYS),
      .rst_n    (NRST),
      .async_in (FUSE_LOCK_SENSE),
      .sync_out (lock_fuse)
   );

   // Override lockout protects bit3 but never the low three bits
   always_comb begin
      ctrl_wmask = MASK_CTRL;
      if (lockout[BIT_LO_OVERRIDE]) begin
         ctrl_wmask = MASK_CTRL & ~MASK_CTRL_GUARDED;
      end
   end

   // Blowing needs the enable bit, an open lock and no lockout
   assign fuse_ok = ctrl[BIT_BLOW_ENABLE]
                  && !lock_fuse
                  && !lockout[BIT_LO_FUSE];

   // Control register, masked write; reserved bits stay zero
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         ctrl <= REG_RESET;
      end else if (hit(REG_REQ.wr, REG_REQ.addr, ADDR_OTP_AND_SHUTDOWN_CTRL)) begin
         ctrl <= (ctrl & ~ctrl_wmask) | (REG_REQ.wdata & ctrl_wmask);
      end
   end

   // Power-down register is exempt from the override lockout
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         pwr <= REG_RESET;
      end else if (hit(REG_REQ.wr, REG_REQ.addr, ADDR_SW_POWER_DOWN_CTRL)) begin
         pwr <= REG_REQ.wdata & MASK_POWER_DOWN;
      end
   end

   // Lockout bits only accumulate; a noisy bus can never clear them
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         lockout <= REG_RESET;
      end else if (hit(REG_REQ.wr, REG_REQ.addr, ADDR_SPECIAL_FUNC_LOCKOUT)) begin
         lockout <= lockout | (REG_REQ.wdata & MASK_LOCKOUT);
      end
   end

   // Read mux; lock register shows only the fuse state
   always_comb begin
      case (REG_REQ.addr)
         ADDR_FUSE_PROGRAM_LOCK: begin
            next_rdata = MASK_LOCK & {8{lock_fuse}};
         end
         ADDR_OTP_AND_SHUTDOWN_CTRL: begin
            next_rdata = ctrl;
         end
         ADDR_SW_POWER_DOWN_CTRL: begin
            next_rdata = pwr;
         end
         ADDR_SPECIAL_FUNC_LOCKOUT: begin
            next_rdata = lockout;
         end
         default: begin
            next_rdata = REG_RESET; // Unmapped offsets read zero
         end
      endcase
   end

   // Read answer one cycle after the strobe; data held until next read
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         RD_DATA  <= REG_RESET;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= REG_REQ.rd;
         if (REG_REQ.rd) begin
            RD_DATA <= next_rdata;
         end
      end
   end

   // Fuse sense current and blow controls
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         SENSE_CURRENT_LOW <= 1'b0;
         FUSE_BLOW_EN      <= 1'b0;
         FUSE_PROG_GO      <= 1'b0;
      end else begin
         SENSE_CURRENT_LOW <= ctrl[BIT_SENSE_LOW];
         FUSE_BLOW_EN      <= fuse_ok;
         FUSE_PROG_GO      <= FUSE_PROG_REQ && fuse_ok;
      end
   end

   // Open-drain shutdown pin: only ever pulls low
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         SHUTDOWN_OUTPUT_O  <= 1'b0;
         SHUTDOWN_OUTPUT_OE <= 1'b0;
      end else begin
         SHUTDOWN_OUTPUT_O  <= 1'b0;
         SHUTDOWN_OUTPUT_OE <= ctrl[BIT_SW_SHUTDOWN] && !lockout[BIT_LO_SHUTDOWN];
      end
   end

   // Override of permanent settings
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         OVERRIDE_ACTIVE <= 1'b0;
      end else begin
         OVERRIDE_ACTIVE <= ctrl[BIT_OVERRIDE] && !lockout[BIT_LO_OVERRIDE];
      end
   end

   // Software power-down; host must first ground the second monitor,
   // this block does not check that level
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         POWER_DOWN <= 1'b0;
      end else begin
         POWER_DOWN <= pwr[BIT_SW_POWER_DOWN] && !lockout[BIT_LO_POWER_DOWN];
      end
   end

   // Checks

   lock_block_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      lock_fuse |=> !FUSE_BLOW_EN && !FUSE_PROG_GO)
      else $error("Fuse programming allowed while lock fuse set");

   lock_read_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      hit(REG_REQ.rd, REG_REQ.addr, ADDR_FUSE_PROGRAM_LOCK)
      |=> RD_VALID && RD_DATA == (MASK_LOCK & {8{$past(lock_fuse)}}))
      else $error("Lock register read wrong");

   sense_sel_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      1'b1 |=> SENSE_CURRENT_LOW == $past(ctrl[BIT_SENSE_LOW]))
      else $error("Sense current select not followed");

   blow_gate_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      FUSE_PROG_GO |-> $past(FUSE_PROG_REQ) && $past(ctrl[BIT_BLOW_ENABLE]))
      else $error("Fuse program issued without blow enable");

   shutdown_output_gate_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      ctrl[BIT_SW_SHUTDOWN] && !lockout[BIT_LO_SHUTDOWN]
      |=> SHUTDOWN_OUTPUT_OE && !SHUTDOWN_OUTPUT_O)
      else $error("Shutdown output not pulled low");

   shutdown_output_lock_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      lockout[BIT_LO_SHUTDOWN] |=> !SHUTDOWN_OUTPUT_OE)
      else $error("Shutdown asserted despite lockout");

   override_on_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      OVERRIDE_ACTIVE |-> $past(ctrl[BIT_OVERRIDE]) && !$past(lockout[BIT_LO_OVERRIDE]))
      else $error("Override active without cause");

   guard_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      hit(REG_REQ.wr, REG_REQ.addr, ADDR_OTP_AND_SHUTDOWN_CTRL) && lockout[BIT_LO_OVERRIDE]
      |=> ctrl[BIT_OVERRIDE] == $past(ctrl[BIT_OVERRIDE])
          && (ctrl & MASK_CTRL & ~MASK_CTRL_GUARDED)
             == ($past(REG_REQ.wdata) & MASK_CTRL & ~MASK_CTRL_GUARDED))
      else $error("Guarded control bits mishandled");

   fuse_lock_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      lockout[BIT_LO_FUSE] |=> !FUSE_BLOW_EN ##1 !FUSE_BLOW_EN)
      else $error("Fuse programming despite lockout");

   pd_on_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      hit(REG_REQ.wr, REG_REQ.addr, ADDR_SW_POWER_DOWN_CTRL)
      && REG_REQ.wdata[BIT_SW_POWER_DOWN] && !lockout[BIT_LO_POWER_DOWN]
      |=> ##1 POWER_DOWN)
      else $error("Power-down request not honoured");

   pd_lock_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      lockout[BIT_LO_POWER_DOWN] |=> !POWER_DOWN)
      else $error("Power-down despite lockout");

   lockout_sticky_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      ##1 ((lockout & $past(lockout)) == $past(lockout)))
      else $error("Lockout bit cleared");

   reserved_zero_a: assert property (
      @(posedge CLK_SYS) disable iff (!NRST)
      (ctrl & ~MASK_CTRL) == 8'h00 && (pwr & ~MASK_POWER_DOWN) == 8'h00
      && (lockout & ~MASK_LOCKOUT) == 8'h00)
      else $error("Reserved bit set");

endmodule
